// ==== ssc_delay_counter.sv ====
// clock-stabilisation delay counter with selectable long or short length
`timescale 1ns/1ps
module ssc_delay_counter #(
  parameter int DLY_W = ssc_pkg::SSC_DLY_W,
  parameter int LONG_CYCLES = ssc_pkg::SSC_LONG_CYCLES,
  parameter int SHORT_CYCLES = ssc_pkg::SSC_SHORT_CYCLES
) (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  // control
  input wire logic start_in,
  input wire logic short_sel_in,
  input wire logic abort_in,
  // status
  output logic busy_out,
  output logic done_out
);
  import ssc_pkg::*;

  localparam logic [DLY_W-1:0] LONG_LOAD = DLY_W'(LONG_CYCLES - 1);
  localparam logic [DLY_W-1:0] SHORT_LOAD = DLY_W'(SHORT_CYCLES - 1);

  logic [DLY_W-1:0] count;
  logic busy;
  wire [DLY_W-1:0] load_value = short_sel_in ? SHORT_LOAD : LONG_LOAD;
  wire at_end = busy && (count == '0);

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count <= '0;
      busy <= 1'b0;
    end else if (start_in) begin
      count <= load_value;
      busy <= 1'b1;
    end else if (abort_in || at_end) begin
      busy <= 1'b0;
    end else if (busy) begin
      count <= count - 1'b1;
    end
  end

  assign busy_out = busy;
  assign done_out = at_end;

  chk_start_loads: assert property (@(posedge core_clk_in) disable iff (!rst_n_in) start_in |=> busy)
    else $error("delay counter did not start");
endmodule : ssc_delay_counter

// ==== ssc_far_side.sv ====
// far-side model: pins, peripheral requests and interrupt controller around the controller
`timescale 1ns/1ps
module ssc_far_side (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  // requests from the bench
  input wire logic stop_req_in,
  input wire logic pin_reset_req_in,
  input wire logic pin_irq_req_in,
  input wire logic [3:0] periph_req_in,
  input wire logic pending_req_in,
  // observed controller state
  input wire logic fetch_enable_in,
  // towards the controller
  output logic stop_exec_out,
  output logic reset_pin_n_out,
  output logic external_wake_interrupt_pin_n_out,
  output logic [3:0] periph_exit_req_out,
  output logic int_pending_out,
  output logic int_service_done_out
);
  logic [1:0] svc_cnt;
  wire logic [1:0] next_svc_cnt;
  assign reset_pin_n_out = ~pin_reset_req_in;
  assign external_wake_interrupt_pin_n_out = ~pin_irq_req_in;
  assign periph_exit_req_out = periph_req_in;
  assign int_pending_out = pending_req_in;
  // service takes a few fetch cycles, not instantly
  assign next_svc_cnt = (fetch_enable_in && pending_req_in) ? ((svc_cnt == 2'h3) ? svc_cnt : svc_cnt + 2'h1) : 2'h0;
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      stop_exec_out <= 1'b0;
      svc_cnt <= 2'h0;
      int_service_done_out <= 1'b0;
    end else begin
      // a one-cycle stop, repeated every other cycle while stop_req_in stays high, never issued as a loop end
      stop_exec_out <= stop_req_in && !stop_exec_out;
      svc_cnt <= next_svc_cnt;
      int_service_done_out <= (svc_cnt == 2'h2);
    end
  end
endmodule : ssc_far_side

// ==== ssc_pkg.sv ====
// constants, state type and helper functions for the stop-state controller
package ssc_pkg;
  // one clock phase is taken as one core clock period
  localparam int SSC_CLK_PERIOD_NS = 25;
  localparam int SSC_PHASE_NS = 25;
  localparam int SSC_LONG_PHASES = 524284;
  localparam int SSC_SHORT_PHASES = 28;
  localparam int SSC_REARM_PHASES = 17;
  localparam int SSC_LONG_CYCLES = SSC_LONG_PHASES * SSC_PHASE_NS / SSC_CLK_PERIOD_NS;
  localparam int SSC_SHORT_CYCLES = SSC_SHORT_PHASES * SSC_PHASE_NS / SSC_CLK_PERIOD_NS;
  localparam int SSC_REARM_CYCLES = SSC_REARM_PHASES * SSC_PHASE_NS / SSC_CLK_PERIOD_NS;
  localparam int SSC_DLY_W = 20;
  localparam int SSC_REARM_W = 5;
  localparam logic [SSC_REARM_W-1:0] SSC_REARM_LOAD = 5'(SSC_REARM_CYCLES - 1);
  localparam logic [1:0] SSC_STOP_WORDS = 2'h1;
  // values after reset
  localparam logic SSC_RST_CLK_EN = 1'b1;
  localparam logic SSC_RST_FETCH_EN = 1'b1;
  localparam logic SSC_RST_OSC_EN = 1'b1;
  localparam logic SSC_RST_OFF = 1'b0;
  localparam logic SSC_RST_PIN_IDLE = 1'b1;

  typedef enum logic [2:0] {
    SSC_RUN = 3'h0,
    SSC_STOP = 3'h1,
    SSC_WAKE_DLY = 3'h3,
    SSC_REARM = 3'h2,
    SSC_SERVICE = 3'h6,
    SSC_RST_HOLD = 3'h5,
    SSC_RST_DLY = 3'h4
  } ssc_state_type;

  function automatic logic ssc_clocks_on(input ssc_state_type s);
    return (s == SSC_RUN) || (s == SSC_REARM) || (s == SSC_SERVICE) || (s == SSC_RST_HOLD);
  endfunction : ssc_clocks_on

  function automatic logic ssc_is_delay(input ssc_state_type s);
    return (s == SSC_WAKE_DLY) || (s == SSC_RST_DLY);
  endfunction : ssc_is_delay
endpackage : ssc_pkg

// ==== ssc_stop_controller.sv ====
// stop-state controller: clock gating, wake arbitration and recovery sequencing
//
// Summary of operation
// - stop suspends core until reset, irq, peripheral
// - stop gates core and peripheral clocks off
// - timers keep running, each individually powerable down
// - oscillator may also be disabled in stop
// - reset pin exit enters reset processing
// - reset recovery delay chosen by stop delay select
// - irq wake services highest priority pending interrupt
// - wake delay 524284 or 28 phases by select
// - interrupts cleared in delay, arbitrated at 17T
// - resume after service, or directly if none
// - no instruction fetch while stopped
// - stop leaves condition codes unchanged
// - stop is one word, no fixed cycles
`timescale 1ns/1ps
module ssc_stop_controller #(
  parameter int NUM_PERIPH = 4,
  parameter int NUM_TIMERS = 2,
  parameter int LONG_CYCLES = ssc_pkg::SSC_LONG_CYCLES,
  parameter int SHORT_CYCLES = ssc_pkg::SSC_SHORT_CYCLES
) (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  // core side
  input wire logic stop_exec_in,
  input wire logic stop_delay_select_in,
  input wire logic osc_off_select_in,
  input wire logic int_pending_in,
  input wire logic int_service_done_in,
  // pins
  input wire logic reset_pin_n_in,
  input wire logic external_wake_interrupt_pin_n_in,
  // peripherals
  input wire logic [NUM_PERIPH-1:0] periph_exit_req_in,
  input wire logic [NUM_TIMERS-1:0] timer_power_down_in,
  // clock and power control
  output logic core_clk_en_out,
  output logic periph_clk_en_out,
  output logic [NUM_TIMERS-1:0] timer_clk_en_out,
  output logic osc_enable_out,
  // program control
  output logic fetch_enable_out,
  output logic cc_update_en_out,
  output logic pc_advance_out,
  output logic [1:0] pc_step_out,
  output logic resume_out,
  // interrupt and reset sequencing
  output logic int_clear_out,
  output logic int_arbitrate_out,
  output logic reset_proc_out,
  output logic stopped_out
);
  import ssc_pkg::*;

  ssc_state_type state;
  ssc_state_type next_state;
  logic reset_low;
  logic irq_low;
  logic periph_req;
  logic dly_busy;
  logic dly_done;
  logic sd_latched;
  logic osc_off;
  logic [SSC_REARM_W-1:0] rearm_cnt;
  logic [SSC_REARM_W-1:0] next_rearm_cnt;

  ssc_wake_detect #(
    .NUM_PERIPH(NUM_PERIPH)
  ) u_wake (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .reset_pin_n_in(reset_pin_n_in),
    .external_wake_interrupt_pin_n_in(external_wake_interrupt_pin_n_in),
    .periph_exit_req_in(periph_exit_req_in),
    .reset_low_out(reset_low),
    .irq_low_out(irq_low),
    .periph_req_out(periph_req)
  );

  // transition decode
  wire stop_entry = (state == SSC_RUN) && stop_exec_in;
  wire wake_req = irq_low || periph_req;
  wire rearm_end = (state == SSC_REARM) && (rearm_cnt == '0);
  wire rearm_entry = (state == SSC_WAKE_DLY) && (next_state == SSC_REARM);
  wire dly_start = ((state == SSC_STOP) && (next_state == SSC_WAKE_DLY))
                   || ((state == SSC_RST_HOLD) && (next_state == SSC_RST_DLY));
  wire dly_abort = ssc_is_delay(state) && (next_state == SSC_RST_HOLD);
  wire sd_now = stop_entry ? stop_delay_select_in : sd_latched;
  wire osc_off_now = stop_entry ? osc_off_select_in : osc_off;

  // one counter serves both recovery paths; its length select is frozen at stop entry
  ssc_delay_counter #(
    .DLY_W(SSC_DLY_W),
    .LONG_CYCLES(LONG_CYCLES),
    .SHORT_CYCLES(SHORT_CYCLES)
  ) u_delay (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .start_in(dly_start),
    .short_sel_in(sd_latched),
    .abort_in(dly_abort),
    .busy_out(dly_busy),
    .done_out(dly_done)
  );

  always_comb begin
    next_state = state;
    unique case (state)
      SSC_RUN: begin
        if (stop_exec_in) begin
          next_state = SSC_STOP;
        end
      end
      SSC_STOP: begin
        if (reset_low) begin
          next_state = SSC_RST_HOLD;
        end else if (wake_req) begin
          next_state = SSC_WAKE_DLY;
        end
      end
      SSC_WAKE_DLY: begin
        if (reset_low) begin
          next_state = SSC_RST_HOLD;
        end else if (dly_done) begin
          next_state = SSC_REARM;
        end
      end
      SSC_REARM: begin
        if (rearm_end) begin
          // the controller picks the winner; the pin's own request gets no preference
          next_state = int_pending_in ? SSC_SERVICE : SSC_RUN;
        end
      end
      SSC_SERVICE: begin
        if (int_service_done_in) begin
          next_state = SSC_RUN;
        end
      end
      SSC_RST_HOLD: begin
        if (!reset_low) begin
          next_state = SSC_RST_DLY;
        end
      end
      SSC_RST_DLY: begin
        if (reset_low) begin
          next_state = SSC_RST_HOLD;
        end else if (dly_done) begin
          next_state = SSC_RUN;
        end
      end
      default: begin
        next_state = SSC_RUN;
      end
    endcase
  end

  // arbitration window counts down from its load to zero, 17 cycles in all
  assign next_rearm_cnt = rearm_entry ? SSC_REARM_LOAD
                          : ((state == SSC_REARM) && (rearm_cnt != '0)) ? rearm_cnt - 1'b1
                          : rearm_cnt;

  // output decode from the next state, so every output lines up with the state
  wire next_clk_en = ssc_clocks_on(next_state);
  wire next_fetch_en = (next_state == SSC_RUN) || (next_state == SSC_SERVICE);
  wire next_cc_en = (next_state == SSC_RUN);
  wire next_osc_en = !((next_state == SSC_STOP) && osc_off_now);
  wire next_int_clear = (next_state == SSC_WAKE_DLY);
  wire next_resume = ((state == SSC_REARM) || (state == SSC_SERVICE)) && (next_state == SSC_RUN);
  wire next_reset_proc = (next_state == SSC_RST_HOLD) || (next_state == SSC_RST_DLY);
  wire next_stopped = (next_state == SSC_STOP) || (next_state == SSC_WAKE_DLY);
  wire [1:0] next_pc_step = stop_entry ? SSC_STOP_WORDS : 2'h0;

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state <= SSC_RUN;
      rearm_cnt <= '0;
      sd_latched <= SSC_RST_OFF;
      osc_off <= SSC_RST_OFF;
    end else begin
      state <= next_state;
      rearm_cnt <= next_rearm_cnt;
      sd_latched <= sd_now;
      osc_off <= osc_off_now;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      core_clk_en_out <= SSC_RST_CLK_EN;
      periph_clk_en_out <= SSC_RST_CLK_EN;
      osc_enable_out <= SSC_RST_OSC_EN;
      fetch_enable_out <= SSC_RST_FETCH_EN;
      cc_update_en_out <= SSC_RST_CLK_EN;
      stopped_out <= SSC_RST_OFF;
      reset_proc_out <= SSC_RST_OFF;
    end else begin
      core_clk_en_out <= next_clk_en;
      periph_clk_en_out <= next_clk_en;
      // core_clk_in must stay free running; the oscillator gate only serves loads downstream
      osc_enable_out <= next_osc_en;
      fetch_enable_out <= next_fetch_en;
      cc_update_en_out <= next_cc_en;
      stopped_out <= next_stopped;
      reset_proc_out <= next_reset_proc;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      timer_clk_en_out <= {NUM_TIMERS{SSC_RST_CLK_EN}};
      pc_advance_out <= SSC_RST_OFF;
      pc_step_out <= 2'h0;
      resume_out <= SSC_RST_OFF;
      int_clear_out <= SSC_RST_OFF;
      int_arbitrate_out <= SSC_RST_OFF;
    end else begin
      // timers ignore the stop state entirely
      timer_clk_en_out <= ~timer_power_down_in;
      pc_advance_out <= stop_entry;
      pc_step_out <= next_pc_step;
      resume_out <= next_resume;
      int_clear_out <= next_int_clear;
      int_arbitrate_out <= rearm_entry;
    end
  end

  // cycle count of the current delay state, read only by the checks below
  logic [31:0] chk_dly_cycles;
  wire [31:0] dly_expect = sd_latched ? 32'(SHORT_CYCLES) : 32'(LONG_CYCLES);

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      chk_dly_cycles <= 32'h0;
    end else if (ssc_is_delay(state) && (next_state == state)) begin
      chk_dly_cycles <= chk_dly_cycles + 32'h1;
    end else begin
      chk_dly_cycles <= 32'h0;
    end
  end

  default clocking chk_cb @(posedge core_clk_in);
  endclocking
  default disable iff (!rst_n_in);

  chk_stop_entry: assert property (stop_entry |=> state == SSC_STOP && stopped_out && !fetch_enable_out)
    else $error("stop instruction did not enter stop state");
  chk_stop_gates_clk: assert property (state == SSC_STOP |-> !core_clk_en_out && !periph_clk_en_out)
    else $error("clocks running in stop state");
  chk_timer_free: assert property (##1 timer_clk_en_out == ~$past(timer_power_down_in))
    else $error("timer clock enable not following power down");
  chk_osc_gated: assert property (state == SSC_STOP && osc_off |-> !osc_enable_out)
    else $error("oscillator left on in stop state");
  chk_reset_exit: assert property (state == SSC_STOP && reset_low |=> state == SSC_RST_HOLD && reset_proc_out)
    else $error("reset pin did not start reset processing");
  chk_reset_delay: assert property (state == SSC_RST_DLY && dly_done && !reset_low
                                    |-> chk_dly_cycles + 32'h1 == dly_expect)
    else $error("reset recovery delay has wrong length");
  chk_pending_service: assert property (rearm_end && int_pending_in |=> state == SSC_SERVICE && fetch_enable_out)
    else $error("pending interrupt not serviced after wake");
  chk_wake_delay: assert property (rearm_entry |-> chk_dly_cycles + 32'h1 == dly_expect)
    else $error("wake delay has wrong length");
  chk_delay_bound: assert property (ssc_is_delay(state) |-> chk_dly_cycles < dly_expect)
    else $error("delay state overran its count");
  chk_int_cleared: assert property (state == SSC_WAKE_DLY |-> int_clear_out && !int_arbitrate_out)
    else $error("interrupts not held clear during delay");
  chk_rearm_len: assert property ($rose(state == SSC_REARM) |-> int_arbitrate_out ##16 state == SSC_REARM
                                  ##1 state != SSC_REARM)
    else $error("arbitration period is not 17 cycles");
  chk_direct_resume: assert property (rearm_end && !int_pending_in |=> state == SSC_RUN && resume_out)
    else $error("no direct resume without pending interrupt");
  chk_no_fetch: assert property (stopped_out |-> !fetch_enable_out && !core_clk_en_out)
    else $error("fetch enabled while stopped");
  chk_cc_hold: assert property (state != SSC_RUN |-> !cc_update_en_out)
    else $error("condition codes writable outside run");
  chk_pc_step: assert property (pc_advance_out |-> pc_step_out == SSC_STOP_WORDS && $past(state) == SSC_RUN)
    else $error("stop advanced the counter by the wrong amount");

  // exit paths, single-cycle pulses and pin latency
  chk_irq_wake: assert property (state == SSC_STOP && !reset_low && wake_req
                                 |=> state == SSC_WAKE_DLY && int_clear_out && osc_enable_out)
    else $error("wake request did not start the delay");
  chk_wake_reset: assert property (state == SSC_WAKE_DLY && reset_low |=> state == SSC_RST_HOLD && reset_proc_out)
    else $error("reset pin ignored during wake delay");
  chk_rst_dly_gated: assert property (state == SSC_RST_DLY |-> !core_clk_en_out && !fetch_enable_out && reset_proc_out)
    else $error("reset recovery delay not gated");
  chk_osc_in_delay: assert property (ssc_is_delay(state) |-> osc_enable_out)
    else $error("oscillator off during stabilisation delay");
  chk_arb_pulse: assert property (int_arbitrate_out |=> !int_arbitrate_out)
    else $error("arbitrate strobe longer than one cycle");
  chk_resume_pulse: assert property (resume_out |=> !resume_out)
    else $error("resume strobe longer than one cycle");
  chk_clk_in_run: assert property (state == SSC_RUN |-> core_clk_en_out && periph_clk_en_out)
    else $error("clocks gated while running");
  chk_service_hold: assert property (state == SSC_SERVICE && !int_service_done_in |=> state == SSC_SERVICE)
    else $error("service left before it finished");
  chk_delay_busy: assert property (ssc_is_delay(state) |-> dly_busy)
    else $error("delay state without a running counter");
  // a pin held low for two edges must show as a request at the third
  chk_irq_sync_lag: assert property (!external_wake_interrupt_pin_n_in ##1 !external_wake_interrupt_pin_n_in
                                     |=> irq_low)
    else $error("interrupt pin level not seen after two flops");
  chk_rst_sync_lag: assert property (!reset_pin_n_in ##1 !reset_pin_n_in |=> reset_low)
    else $error("reset pin level not seen after two flops");
endmodule : ssc_stop_controller

// ==== ssc_wake_detect.sv ====
// wake-source detection: pin synchronisers and peripheral exit request merge
`timescale 1ns/1ps
module ssc_wake_detect #(
  parameter int NUM_PERIPH = 4
) (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  // wake sources
  input wire logic reset_pin_n_in,
  input wire logic external_wake_interrupt_pin_n_in,
  input wire logic [NUM_PERIPH-1:0] periph_exit_req_in,
  // detected levels
  output logic reset_low_out,
  output logic irq_low_out,
  output logic periph_req_out
);
  import ssc_pkg::*;

  logic [1:0] reset_sync;
  logic [1:0] irq_sync;

  // runs on the free clock, never the gated one, so a wake is always seen
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      reset_sync <= {2{SSC_RST_PIN_IDLE}};
      irq_sync <= {2{SSC_RST_PIN_IDLE}};
    end else begin
      reset_sync <= {reset_sync[0], reset_pin_n_in};
      irq_sync <= {irq_sync[0], external_wake_interrupt_pin_n_in};
    end
  end

  // level sensitive: a held low keeps the request standing
  assign reset_low_out = !reset_sync[1];
  assign irq_low_out = !irq_sync[1];
  assign periph_req_out = |periph_exit_req_in;
endmodule : ssc_wake_detect

// ==== tb_stop_state_controller.sv ====
// self-checking bench for the stop-state controller
`timescale 1ns/1ps
module tb_stop_state_controller;
  import ssc_pkg::*;
  // long count shortened so the run stays brief
  localparam int LONG_N = 40;
  localparam int SHORT_N = 28;
  logic core_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic stop_req = 1'b0;
  logic stop_delay_select = 1'b0;
  logic osc_off_select = 1'b0;
  logic rst_req = 1'b0;
  logic irq_req = 1'b0;
  logic pending_req = 1'b0;
  logic [3:0] periph_req = 4'h0;
  logic [1:0] timer_power_down = 2'h0;
  logic stop_exec, int_pending, int_service_done, reset_pin_n, irq_pin_n;
  logic [3:0] periph_exit_req;
  logic core_clk_en_out, periph_clk_en_out, osc_enable_out, fetch_enable_out, cc_update_en_out;
  logic pc_advance_out, resume_out, int_clear_out, int_arbitrate_out, reset_proc_out, stopped_out;
  logic [1:0] timer_clk_en_out;
  logic [1:0] pc_step_out;
  int n_mismatch = 0;
  int comparisons = 0;

  always #12.5 core_clk_in = ~core_clk_in;

  ssc_far_side far (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .stop_req_in(stop_req),
    .pin_reset_req_in(rst_req), .pin_irq_req_in(irq_req), .periph_req_in(periph_req),
    .pending_req_in(pending_req), .fetch_enable_in(fetch_enable_out), .stop_exec_out(stop_exec),
    .reset_pin_n_out(reset_pin_n), .external_wake_interrupt_pin_n_out(irq_pin_n),
    .periph_exit_req_out(periph_exit_req), .int_pending_out(int_pending),
    .int_service_done_out(int_service_done));

  ssc_stop_controller #(.NUM_PERIPH(4), .NUM_TIMERS(2), .LONG_CYCLES(LONG_N), .SHORT_CYCLES(SHORT_N)) dut (
    .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .stop_exec_in(stop_exec),
    .stop_delay_select_in(stop_delay_select), .osc_off_select_in(osc_off_select),
    .int_pending_in(int_pending), .int_service_done_in(int_service_done), .reset_pin_n_in(reset_pin_n),
    .external_wake_interrupt_pin_n_in(irq_pin_n), .periph_exit_req_in(periph_exit_req),
    .timer_power_down_in(timer_power_down), .core_clk_en_out(core_clk_en_out),
    .periph_clk_en_out(periph_clk_en_out), .timer_clk_en_out(timer_clk_en_out), .osc_enable_out(osc_enable_out),
    .fetch_enable_out(fetch_enable_out), .cc_update_en_out(cc_update_en_out), .pc_advance_out(pc_advance_out),
    .pc_step_out(pc_step_out), .resume_out(resume_out), .int_clear_out(int_clear_out),
    .int_arbitrate_out(int_arbitrate_out), .reset_proc_out(reset_proc_out), .stopped_out(stopped_out));

  // sample just after the edge so its updates have landed
  task automatic tick;
    @(posedge core_clk_in);
    #1;
  endtask : tick

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk

  task automatic final_report;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : final_report

  task automatic t_reset_values;
    chk("reset outputs", 32'h3ff, {core_clk_en_out, periph_clk_en_out, timer_clk_en_out, osc_enable_out,
      fetch_enable_out, cc_update_en_out, ~stopped_out, ~reset_proc_out, ~int_clear_out});
  endtask : t_reset_values

  task automatic enter_stop(input logic sel, input logic osc);
    int i;
    @(posedge core_clk_in);
    stop_delay_select <= sel;
    osc_off_select <= osc;
    stop_req <= 1'b1;
    @(posedge core_clk_in);
    stop_req <= 1'b0;
    for (i = 0; i < 5 && stopped_out !== 1'b1; i++) tick;
    chk("stopped", 1'b1, stopped_out);
    chk("clocks gated", 2'h0, {core_clk_en_out, periph_clk_en_out});
    chk("fetch off", 1'b0, fetch_enable_out);
    chk("cc frozen", 1'b0, cc_update_en_out);
    chk("pc advance", 3'h5, {pc_advance_out, pc_step_out});
    chk("osc enable", !osc, osc_enable_out);
    tick;
    chk("pc advance ends", 3'h0, {pc_advance_out, pc_step_out});
  endtask : enter_stop

  task automatic t_irq_wake(input logic sel, input logic pend);
    int i;
    int n;
    enter_stop(sel, 1'b1);
    @(posedge core_clk_in);
    irq_req <= 1'b1;
    pending_req <= pend;
    for (i = 0; i < 10 && int_clear_out !== 1'b1; i++) tick;
    chk("osc back for delay", 1'b1, osc_enable_out);
    chk("still stopped in delay", 2'h2, {stopped_out, fetch_enable_out});
    n = 1;
    @(posedge core_clk_in);
    irq_req <= 1'b0;
    #1;
    while (int_clear_out === 1'b1 && n < 100) begin
      n++;
      tick;
    end
    chk("wake delay", sel ? SHORT_N : LONG_N, n);
    chk("arbitrate at 17T start", 4'ha, {int_arbitrate_out, stopped_out, core_clk_en_out, fetch_enable_out});
    for (i = 0; i < 16; i++) tick;
    chk("no early resume", 2'h0, {resume_out, fetch_enable_out});
    tick;
    chk("resume after 17T", {~pend, 1'b1}, {resume_out, fetch_enable_out});
    if (pend) begin
      for (i = 0; i < 20 && resume_out !== 1'b1; i++) tick;
      chk("resume after service", 1'b1, resume_out);
      @(posedge core_clk_in);
      pending_req <= 1'b0;
      #1;
    end
    chk("cc back on", 1'b1, cc_update_en_out);
  endtask : t_irq_wake

  task automatic t_periph_wake;
    int i;
    enter_stop(1'b1, 1'b0);
    @(posedge core_clk_in);
    timer_power_down <= 2'h1;
    tick;
    tick;
    chk("timers in stop", 2'h2, timer_clk_en_out);
    @(posedge core_clk_in);
    periph_req <= 4'h4;
    timer_power_down <= 2'h0;
    for (i = 0; i < 10 && int_clear_out !== 1'b1; i++) tick;
    chk("periph wake", 1'b1, int_clear_out);
    @(posedge core_clk_in);
    periph_req <= 4'h0;
    for (i = 0; i < 80 && resume_out !== 1'b1; i++) tick;
    chk("periph resume", 1'b1, resume_out);
  endtask : t_periph_wake

  task automatic t_reset_wake;
    int i;
    int n;
    enter_stop(1'b0, 1'b0);
    @(posedge core_clk_in);
    rst_req <= 1'b1;
    for (i = 0; i < 10 && reset_proc_out !== 1'b1; i++) tick;
    chk("reset processing", 3'h6, {reset_proc_out, core_clk_en_out, stopped_out});
    repeat (3) tick;
    @(posedge core_clk_in);
    rst_req <= 1'b0;
    #1;
    for (i = 0; i < 10 && core_clk_en_out !== 1'b0; i++) tick;
    n = 0;
    while (core_clk_en_out === 1'b0 && n < 100) begin
      n++;
      tick;
    end
    chk("reset recovery delay", LONG_N, n);
    chk("run after reset", 3'h2, {reset_proc_out, fetch_enable_out, resume_out});
  endtask : t_reset_wake

  task automatic t_reset_in_delay;
    int i;
    enter_stop(1'b1, 1'b0);
    @(posedge core_clk_in);
    periph_req <= 4'h1;
    #1;
    for (i = 0; i < 10 && int_clear_out !== 1'b1; i++) tick;
    @(posedge core_clk_in);
    periph_req <= 4'h0;
    rst_req <= 1'b1;
    #1;
    for (i = 0; i < 10 && reset_proc_out !== 1'b1; i++) tick;
    chk("reset in delay", 3'h6, {reset_proc_out, core_clk_en_out, stopped_out});
    @(posedge core_clk_in);
    rst_req <= 1'b0;
    #1;
    for (i = 0; i < 60 && fetch_enable_out !== 1'b1; i++) tick;
    chk("run after reset in delay", 3'h2, {reset_proc_out, fetch_enable_out, resume_out});
  endtask : t_reset_in_delay

  // a hang is cut short well past the expected run
  initial begin
    #(25 * 5000);
    n_mismatch++;
    final_report();
  end

  initial begin
    repeat (5) @(posedge core_clk_in);
    rst_n_in <= 1'b1;
    tick;
    t_reset_values();
    t_irq_wake(1'b1, 1'b0);
    t_irq_wake(1'b0, 1'b0);
    t_irq_wake(1'b1, 1'b1);
    t_periph_wake();
    t_reset_wake();
    t_reset_in_delay();
    final_report();
  end
endmodule : tb_stop_state_controller
